// file: common/record_path_pkg.sv
// constants, field layouts and carrier types of the record path configuration registers
package record_path_pkg;

    localparam int          ADDR_W          = 16;
    localparam int          AMP_CHANNELS    = 2;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [15:0] DMIC_BEEP_OFS   = 16'h4008;
    localparam logic [15:0] REC_POWER_OFS   = 16'h4009;
    localparam logic [15:0] GAIN_LEFT_OFS   = 16'h400E;
    localparam logic [15:0] GAIN_RIGHT_OFS  = 16'h400F;
    localparam logic [15:0] BEEP_ENABLE_OFS = 16'h4010;

    // ------------------------------------------------------------------
    // writable-bit masks and reset values
    // ------------------------------------------------------------------
    localparam logic [7:0]  DMIC_BEEP_MASK  = 8'h3F;
    localparam logic [7:0]  REC_POWER_MASK  = 8'h7E;
    localparam logic [7:0]  AMP_GAIN_MASK   = 8'hE7;
    localparam logic [7:0]  BEEP_EN_MASK    = 8'h10;
    localparam logic [7:0]  REG_RESET_VAL   = 8'h00;
    localparam logic [7:0]  UNMAPPED_RDATA  = 8'h00;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int          DMIC_LSB        = 4;
    localparam int          BEEP_UNMUTE_BIT = 3;
    localparam int          BEEP_GAIN_LSB   = 0;
    localparam int          BOOST_LSB       = 5;
    localparam int          ADC_BIAS_LSB    = 3;
    localparam int          FE_BIAS_LSB     = 1;
    localparam int          AMP_GAIN_LSB    = 5;
    localparam int          AMP_SE_BIT      = 2;
    localparam int          AMP_UNMUTE_BIT  = 1;
    localparam int          AMP_EN_BIT      = 0;
    localparam int          BEEP_EN_BIT     = 4;

    // ------------------------------------------------------------------
    // encodings and carriers
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        DMIC_NONE   = 2'h0,
        DMIC_FIRST  = 2'h1,
        DMIC_SECOND = 2'h2,
        DMIC_RSVD   = 2'h3
    } dmic_sel_t;

    typedef enum logic [1:0] {
        BIAS_NORMAL        = 2'h0,
        BIAS_EXTREME_SAVE  = 2'h1,
        BIAS_SAVE          = 2'h2,
        BIAS_ENHANCED      = 2'h3
    } bias_mode_t;

    typedef struct packed {
        logic [5:0] gain_db;
        logic       single_ended_mic_pin_sel;
        logic       positive_diff_pin_en;
        logic       complement_to_cm;
        logic       pass;
        logic       power;
    } amp_ctrl_t;

    localparam amp_ctrl_t AMP_CTRL_RESET = '{6'h00, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};

    function automatic logic [5:0] amp_gain_db(input logic [2:0] code);
        case (code)
            3'h0:    amp_gain_db = 6'h00;
            3'h1:    amp_gain_db = 6'h06;
            3'h2:    amp_gain_db = 6'h0A;
            3'h3:    amp_gain_db = 6'h0E;
            3'h4:    amp_gain_db = 6'h11;
            3'h5:    amp_gain_db = 6'h14;
            3'h6:    amp_gain_db = 6'h1A;
            default: amp_gain_db = 6'h20;
        endcase
    endfunction

    // beep code 100 is a cut, not a boost
    function automatic logic signed [6:0] beep_gain_db(input logic [2:0] code);
        case (code)
            3'h0:    beep_gain_db = 7'sh00;
            3'h1:    beep_gain_db = 7'sh06;
            3'h2:    beep_gain_db = 7'sh0A;
            3'h3:    beep_gain_db = 7'sh0E;
            3'h4:    beep_gain_db = -7'sh17;
            3'h5:    beep_gain_db = 7'sh14;
            3'h6:    beep_gain_db = 7'sh1A;
            default: beep_gain_db = 7'sh20;
        endcase
    endfunction

endpackage

// file: hw/input_amp_ctrl.sv
// one input gain amplifier channel: decodes its register byte into registered controls
`timescale 1ns/1ps
module input_amp_ctrl (
    input  wire logic                        SYS_CLK,
    input  wire logic                        RESET,
    input  wire logic [7:0]                  gain_reg,
    input  wire logic                        front_end_pd,
    output record_path_pkg::amp_ctrl_t       ctrl
);
    import record_path_pkg::*;

    amp_ctrl_t state_q;
    amp_ctrl_t state_d;

    always_comb begin
        state_d = state_q;
        state_d.gain_db = amp_gain_db(gain_reg[AMP_GAIN_LSB +: 3]);
        state_d.single_ended_mic_pin_sel = gain_reg[AMP_SE_BIT];
        state_d.positive_diff_pin_en = !gain_reg[AMP_SE_BIT];
        state_d.complement_to_cm = gain_reg[AMP_SE_BIT];
        state_d.pass = gain_reg[AMP_UNMUTE_BIT];
        // a digital mic keeps the whole analog front end down, amp included
        state_d.power = gain_reg[AMP_EN_BIT] && !front_end_pd;
    end

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            state_q <= AMP_CTRL_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    assign ctrl = state_q;

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RESET);

    AST_AMP_GAIN: assert property (
        gain_reg[7:5] == 3'h4 |=> state_q.gain_db == 6'h11)
        else $error("amp gain code 100 did not give 17 dB");
    AST_AMP_SE: assert property (
        gain_reg[AMP_SE_BIT] |=> state_q.single_ended_mic_pin_sel
        && !state_q.positive_diff_pin_en && state_q.complement_to_cm)
        else $error("single-ended select did not reroute the amplifier inputs");
    AST_AMP_MUTE: assert property (
        !gain_reg[AMP_UNMUTE_BIT] |=> !state_q.pass)
        else $error("amp passes signal while its mute bit is 0");
    AST_AMP_POWER: assert property (
        state_q.power |-> $past(gain_reg[AMP_EN_BIT]))
        else $error("amp powered without its enable bit");

endmodule

// file: hw/record_path_config_regs.sv
// record path configuration registers: storage, read-back and decoded control outputs
`timescale 1ns/1ps
module record_path_config_regs (
    input  wire logic                                   SYS_CLK,
    input  wire logic                                   RESET,
    input  wire logic [record_path_pkg::ADDR_W-1:0]     REG_ADDR,
    input  wire logic [7:0]                             REG_WDATA,
    input  wire logic                                   REG_WR_STB,
    input  wire logic                                   REG_RD_STB,
    output logic [7:0]                                  REG_RDATA,
    output logic                                        REG_RD_VALID,
    output logic                                        FIRST_DIGITAL_MIC_INPUT_EN,
    output logic                                        SECOND_DIGITAL_MIC_INPUT_EN,
    output logic                                        FRONT_END_PD,
    output logic signed [6:0]                           BEEP_GAIN_DB,
    output logic                                        BEEP_PASS,
    output logic [1:0]                                  MIX_BOOST_LEVEL,
    output record_path_pkg::bias_mode_t                 ADC_BIAS_MODE,
    output record_path_pkg::bias_mode_t                 FRONT_END_BIAS_MODE,
    output record_path_pkg::amp_ctrl_t [1:0]            INPUT_GAIN_AMPLIFIER
);
    import record_path_pkg::*;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]        dmic_beep;
        logic [7:0]        rec_power;
        logic [7:0]        gain_left;
        logic [7:0]        gain_right;
        logic [7:0]        beep_enable;
        logic [7:0]        rdata;
        logic              rd_valid;
        logic              dmic_first;
        logic              dmic_second;
        logic              fe_pd;
        logic signed [6:0] beep_gain;
        logic              beep_pass;
        logic [1:0]        boost;
        bias_mode_t        adc_bias;
        bias_mode_t        fe_bias;
    } state_t;

    state_t state_q;
    state_t state_d;
    logic   hit_dmic;
    logic   hit_power;
    logic   hit_left;
    logic   hit_right;
    logic   hit_beep_en;

    assign hit_dmic    = (REG_ADDR == DMIC_BEEP_OFS);
    assign hit_power   = (REG_ADDR == REC_POWER_OFS);
    assign hit_left    = (REG_ADDR == GAIN_LEFT_OFS);
    assign hit_right   = (REG_ADDR == GAIN_RIGHT_OFS);
    assign hit_beep_en = (REG_ADDR == BEEP_ENABLE_OFS);

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        state_d = state_q;

        // reserved bits are masked off on the way in so they can never read back set
        if (REG_WR_STB) begin
            if (hit_dmic) begin
                state_d.dmic_beep = REG_WDATA & DMIC_BEEP_MASK;
            end
            if (hit_power) begin
                state_d.rec_power = REG_WDATA & REC_POWER_MASK;
            end
            if (hit_left) begin
                state_d.gain_left = REG_WDATA & AMP_GAIN_MASK;
            end
            if (hit_right) begin
                state_d.gain_right = REG_WDATA & AMP_GAIN_MASK;
            end
            if (hit_beep_en) begin
                state_d.beep_enable = REG_WDATA & BEEP_EN_MASK;
            end
        end

        // read returns the value held before a same-cycle write
        state_d.rd_valid = REG_RD_STB;
        if (REG_RD_STB) begin
            if (hit_dmic) begin
                state_d.rdata = state_q.dmic_beep;
            end else if (hit_power) begin
                state_d.rdata = state_q.rec_power;
            end else if (hit_left) begin
                state_d.rdata = state_q.gain_left;
            end else if (hit_right) begin
                state_d.rdata = state_q.gain_right;
            end else if (hit_beep_en) begin
                state_d.rdata = state_q.beep_enable;
            end else begin
                state_d.rdata = UNMAPPED_RDATA;
            end
        end

        // decoded outputs follow the new register contents on the same edge
        case (dmic_sel_t'(state_d.dmic_beep[DMIC_LSB +: 2]))
            DMIC_FIRST: begin
                state_d.dmic_first  = 1'b1;
                state_d.dmic_second = 1'b0;
            end
            DMIC_SECOND: begin
                state_d.dmic_first  = 1'b0;
                state_d.dmic_second = 1'b1;
            end
            default: begin
                // reserved code enables nothing, the safest reading
                state_d.dmic_first  = 1'b0;
                state_d.dmic_second = 1'b0;
            end
        endcase
        state_d.fe_pd = state_d.dmic_first || state_d.dmic_second;

        state_d.beep_gain = beep_gain_db(state_d.dmic_beep[BEEP_GAIN_LSB +: 3]);
        state_d.beep_pass = state_d.dmic_beep[BEEP_UNMUTE_BIT]
                            && state_d.beep_enable[BEEP_EN_BIT];

        state_d.boost    = state_d.rec_power[BOOST_LSB +: 2];
        state_d.adc_bias = bias_mode_t'(state_d.rec_power[ADC_BIAS_LSB +: 2]);
        state_d.fe_bias  = bias_mode_t'(state_d.rec_power[FE_BIAS_LSB +: 2]);
    end

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            state_q <= '{
                dmic_beep:   REG_RESET_VAL,
                rec_power:   REG_RESET_VAL,
                gain_left:   REG_RESET_VAL,
                gain_right:  REG_RESET_VAL,
                beep_enable: REG_RESET_VAL,
                rdata:       8'h00,
                rd_valid:    1'b0,
                dmic_first:  1'b0,
                dmic_second: 1'b0,
                fe_pd:       1'b0,
                beep_gain:   7'sh00,
                beep_pass:   1'b0,
                boost:       2'h0,
                adc_bias:    BIAS_NORMAL,
                fe_bias:     BIAS_NORMAL
            };
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------------
    // per-channel input amplifiers
    // ------------------------------------------------------------------
    logic [7:0] amp_reg_next [AMP_CHANNELS];

    assign amp_reg_next[0] = state_d.gain_left;
    assign amp_reg_next[1] = state_d.gain_right;

    generate
        for (genvar ch = 0; ch < AMP_CHANNELS; ch++) begin : g_amp
            input_amp_ctrl u_amp (
                .SYS_CLK      (SYS_CLK),
                .RESET        (RESET),
                .gain_reg     (amp_reg_next[ch]),
                .front_end_pd (state_d.fe_pd),
                .ctrl         (INPUT_GAIN_AMPLIFIER[ch])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign REG_RDATA                   = state_q.rdata;
    assign REG_RD_VALID                = state_q.rd_valid;
    assign FIRST_DIGITAL_MIC_INPUT_EN  = state_q.dmic_first;
    assign SECOND_DIGITAL_MIC_INPUT_EN = state_q.dmic_second;
    assign FRONT_END_PD                = state_q.fe_pd;
    assign BEEP_GAIN_DB                = state_q.beep_gain;
    assign BEEP_PASS                   = state_q.beep_pass;
    assign MIX_BOOST_LEVEL             = state_q.boost;
    assign ADC_BIAS_MODE               = state_q.adc_bias;
    assign FRONT_END_BIAS_MODE         = state_q.fe_bias;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RESET);

    AST_DMIC_FIRST: assert property (
        REG_WR_STB && hit_dmic && REG_WDATA[5:4] == 2'h1
        |=> FIRST_DIGITAL_MIC_INPUT_EN && !SECOND_DIGITAL_MIC_INPUT_EN)
        else $error("code 01 did not enable only the first digital mic");

    AST_DMIC_SECOND: assert property (
        REG_WR_STB && hit_dmic && REG_WDATA[5:4] == 2'h2
        |=> !FIRST_DIGITAL_MIC_INPUT_EN && SECOND_DIGITAL_MIC_INPUT_EN)
        else $error("code 10 did not enable only the second digital mic");

    AST_DMIC_NONE: assert property (
        REG_WR_STB && hit_dmic && REG_WDATA[5:4] == 2'h0
        |=> !FIRST_DIGITAL_MIC_INPUT_EN && !SECOND_DIGITAL_MIC_INPUT_EN)
        else $error("code 00 left a digital mic enabled");

    AST_DMIC_RSVD: assert property (
        REG_WR_STB && hit_dmic && REG_WDATA[5:4] == 2'h3
        |=> !FIRST_DIGITAL_MIC_INPUT_EN && !SECOND_DIGITAL_MIC_INPUT_EN)
        else $error("reserved digital mic code enabled a mic");

    AST_FE_PD: assert property (
        (FIRST_DIGITAL_MIC_INPUT_EN || SECOND_DIGITAL_MIC_INPUT_EN)
        |-> FRONT_END_PD && !INPUT_GAIN_AMPLIFIER[0].power
        && !INPUT_GAIN_AMPLIFIER[1].power)
        else $error("analog front end powered while a digital mic is on");

    AST_BEEP_MUTE: assert property (
        REG_WR_STB && hit_dmic && !REG_WDATA[3]
        |=> !BEEP_PASS)
        else $error("beep passes after mute bit written 0");

    AST_BEEP_UNMUTE: assert property (
        REG_WR_STB && hit_dmic && REG_WDATA[3] && state_q.beep_enable[BEEP_EN_BIT]
        |=> BEEP_PASS)
        else $error("enabled beep stays silent after unmute");

    AST_BEEP_GAIN: assert property (
        REG_WR_STB && hit_dmic && REG_WDATA[2:0] == 3'h4
        |=> BEEP_GAIN_DB == -7'sd23)
        else $error("beep gain code 100 did not give -23 dB");

    AST_BEEP_GAIN_MAX: assert property (
        REG_WR_STB && hit_dmic && REG_WDATA[2:0] == 3'h7
        |=> BEEP_GAIN_DB == 7'sd32)
        else $error("beep gain code 111 did not give +32 dB");

    AST_BEEP_ENABLE: assert property (
        BEEP_PASS
        |-> state_q.beep_enable[BEEP_EN_BIT] && state_q.dmic_beep[BEEP_UNMUTE_BIT])
        else $error("beep passes without enable and unmute");

    // a new enable write in the very next cycle may legally bring the beep back
    AST_BEEP_SILENCE: assert property (
        REG_WR_STB && hit_beep_en && !REG_WDATA[4]
        |=> !BEEP_PASS
        ##1 (!BEEP_PASS || $past(REG_WR_STB && hit_beep_en && REG_WDATA[BEEP_EN_BIT])))
        else $error("beep not silenced after enable cleared");

    AST_BOOST: assert property (
        REG_WR_STB && hit_power && REG_WDATA[6:5] == 2'h2
        |=> MIX_BOOST_LEVEL == 2'h2)
        else $error("boost level two not applied");

    AST_ADC_BIAS: assert property (
        REG_WR_STB && hit_power && REG_WDATA[4:3] == 2'h1
        |=> ADC_BIAS_MODE == BIAS_EXTREME_SAVE)
        else $error("adc bias code 01 did not select extreme power saving");

    AST_ADC_BIAS_ENH: assert property (
        REG_WR_STB && hit_power && REG_WDATA[4:3] == 2'h3
        |=> ADC_BIAS_MODE == BIAS_ENHANCED)
        else $error("adc bias code 11 did not select enhanced performance");

    AST_FE_BIAS: assert property (
        REG_WR_STB && hit_power && REG_WDATA[2:1] == 2'h3
        |=> FRONT_END_BIAS_MODE == BIAS_ENHANCED)
        else $error("front-end bias code 11 did not select enhanced performance");

    AST_FE_BIAS_SAVE: assert property (
        REG_WR_STB && hit_power && REG_WDATA[2:1] == 2'h2
        |=> FRONT_END_BIAS_MODE == BIAS_SAVE)
        else $error("front-end bias code 10 did not select power saving");

    AST_RIGHT_GAIN: assert property (
        REG_WR_STB && hit_right && REG_WDATA[7:5] == 3'h7
        |=> INPUT_GAIN_AMPLIFIER[1].gain_db == 6'h20)
        else $error("right gain code 111 did not give 32 dB");

    AST_RIGHT_SE: assert property (
        REG_WR_STB && hit_right && REG_WDATA[2]
        |=> !INPUT_GAIN_AMPLIFIER[1].positive_diff_pin_en)
        else $error("right positive pin still enabled in single-ended mode");

    AST_RIGHT_DIFF: assert property (
        REG_WR_STB && hit_right && !REG_WDATA[2]
        |=> INPUT_GAIN_AMPLIFIER[1].positive_diff_pin_en
        && !INPUT_GAIN_AMPLIFIER[1].complement_to_cm)
        else $error("right amp left in single-ended routing");

    AST_RIGHT_MUTE: assert property (
        REG_WR_STB && hit_right && !REG_WDATA[1]
        |=> !INPUT_GAIN_AMPLIFIER[1].pass)
        else $error("right amp passes while muted");

    AST_RIGHT_PASS: assert property (
        REG_WR_STB && hit_right && REG_WDATA[1]
        |=> INPUT_GAIN_AMPLIFIER[1].pass)
        else $error("right amp muted while its mute bit is 1");

    AST_RIGHT_POWER: assert property (
        REG_WR_STB && hit_right && !REG_WDATA[0]
        |=> !INPUT_GAIN_AMPLIFIER[1].power)
        else $error("right amp powered with enable cleared");

    AST_RSVD_READ: assert property (
        REG_RD_STB && hit_dmic
        |=> REG_RD_VALID && REG_RDATA[7:6] == 2'h0)
        else $error("reserved bits read back nonzero");

    AST_RSVD_POWER_READ: assert property (
        REG_RD_STB && hit_power
        |=> REG_RD_VALID && !REG_RDATA[7] && !REG_RDATA[0])
        else $error("reserved power bits read back nonzero");

    AST_RSVD_GAIN_READ: assert property (
        REG_RD_STB && (hit_left || hit_right)
        |=> REG_RD_VALID && REG_RDATA[4:3] == 2'h0)
        else $error("reserved gain bits read back nonzero");

    AST_UNMAPPED_READ: assert property (
        REG_RD_STB && !(hit_dmic || hit_power || hit_left || hit_right || hit_beep_en)
        |=> REG_RD_VALID && REG_RDATA == 8'h00)
        else $error("unmapped address read back nonzero");

endmodule

// file: testbench/record_path_config_regs_tb.sv
// self-checking testbench of the record path configuration registers
`timescale 1ns/1ps
module record_path_config_regs_tb;
    import record_path_pkg::*;

    logic              SYS_CLK;
    logic              RESET;
    logic [15:0]       REG_ADDR;
    logic [7:0]        REG_WDATA;
    logic              REG_WR_STB;
    logic              REG_RD_STB;
    logic [7:0]        REG_RDATA;
    logic              REG_RD_VALID;
    logic              FIRST_DIGITAL_MIC_INPUT_EN;
    logic              SECOND_DIGITAL_MIC_INPUT_EN;
    logic              FRONT_END_PD;
    logic signed [6:0] BEEP_GAIN_DB;
    logic              BEEP_PASS;
    logic [1:0]        MIX_BOOST_LEVEL;
    bias_mode_t        ADC_BIAS_MODE;
    bias_mode_t        FRONT_END_BIAS_MODE;
    amp_ctrl_t [1:0]   INPUT_GAIN_AMPLIFIER;
    int                mismatches = 0;
    int                n_tests = 0;
    int                cycles = 0;

    localparam logic [15:0] ADDRS [5] = '{16'h4008, 16'h4009, 16'h400E, 16'h400F, 16'h4010};
    localparam logic [7:0]  MASKS [5] = '{8'h3F, 8'h7E, 8'hE7, 8'hE7, 8'h10};
    localparam logic [5:0]  AMP_DB [8] = '{6'h00, 6'h06, 6'h0A, 6'h0E, 6'h11, 6'h14, 6'h1A, 6'h20};
    // code 100 is a 23 dB cut, held here in two's complement
    localparam logic [6:0]  BEEP_DB [8] = '{7'h00, 7'h06, 7'h0A, 7'h0E, 7'h69, 7'h14, 7'h1A, 7'h20};

    record_path_config_regs u_record_path_config_regs (
        .SYS_CLK                     (SYS_CLK),
        .RESET                       (RESET),
        .REG_ADDR                    (REG_ADDR),
        .REG_WDATA                   (REG_WDATA),
        .REG_WR_STB                  (REG_WR_STB),
        .REG_RD_STB                  (REG_RD_STB),
        .REG_RDATA                   (REG_RDATA),
        .REG_RD_VALID                (REG_RD_VALID),
        .FIRST_DIGITAL_MIC_INPUT_EN  (FIRST_DIGITAL_MIC_INPUT_EN),
        .SECOND_DIGITAL_MIC_INPUT_EN (SECOND_DIGITAL_MIC_INPUT_EN),
        .FRONT_END_PD                (FRONT_END_PD),
        .BEEP_GAIN_DB                (BEEP_GAIN_DB),
        .BEEP_PASS                   (BEEP_PASS),
        .MIX_BOOST_LEVEL             (MIX_BOOST_LEVEL),
        .ADC_BIAS_MODE               (ADC_BIAS_MODE),
        .FRONT_END_BIAS_MODE         (FRONT_END_BIAS_MODE),
        .INPUT_GAIN_AMPLIFIER        (INPUT_GAIN_AMPLIFIER)
    );

    initial begin
        SYS_CLK = 1'b0;
        forever #5 SYS_CLK = ~SYS_CLK;
    end

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // the idle cycle at the end keeps two strobes of back-to-back calls apart
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        REG_ADDR = a;
        REG_WDATA = d;
        REG_WR_STB = 1'b1;
        @(posedge SYS_CLK);
        #1;
        REG_WR_STB = 1'b0;
        @(posedge SYS_CLK);
        #1;
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        REG_ADDR = a;
        REG_RD_STB = 1'b1;
        @(posedge SYS_CLK);
        #1;
        REG_RD_STB = 1'b0;
        chk("read valid", {7'h00, REG_RD_VALID}, 8'h01);
        chk("read data", REG_RDATA, exp);
        @(posedge SYS_CLK);
        #1;
        chk("read valid drop", {7'h00, REG_RD_VALID}, 8'h00);
    endtask

    task automatic do_reset;
        RESET = 1'b1;
        repeat (6) @(posedge SYS_CLK);
        #1;
        RESET = 1'b0;
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic check_reset_state;
        for (int i = 0; i < 5; i++) rd(ADDRS[i], 8'h00);
        chk("dmic", {6'h00, FIRST_DIGITAL_MIC_INPUT_EN, SECOND_DIGITAL_MIC_INPUT_EN}, 8'h00);
        chk("pd pass", {6'h00, FRONT_END_PD, BEEP_PASS}, 8'h00);
        chk("power reg", {2'h0, MIX_BOOST_LEVEL, ADC_BIAS_MODE, FRONT_END_BIAS_MODE}, 8'h00);
        chk("amp left", {3'h0, INPUT_GAIN_AMPLIFIER[0][4:0]}, 8'h08);
        chk("amp right", {3'h0, INPUT_GAIN_AMPLIFIER[1][4:0]}, 8'h08);
        chk("amp left gain", {2'h0, INPUT_GAIN_AMPLIFIER[0].gain_db}, 8'h00);
        chk("amp right gain", {2'h0, INPUT_GAIN_AMPLIFIER[1].gain_db}, 8'h00);
    endtask

    task automatic test_masks;
        for (int i = 0; i < 5; i++) begin
            wr(ADDRS[i], 8'hFF);
            rd(ADDRS[i], MASKS[i]);
            wr(ADDRS[i], 8'h00);
        end
        wr(16'h4011, 8'hFF);
        rd(16'h4011, 8'h00);
        rd(16'h4007, 8'h00);
    endtask

    task automatic test_dmic;
        wr(GAIN_LEFT_OFS, 8'h01);
        wr(GAIN_RIGHT_OFS, 8'h01);
        for (int c = 0; c < 4; c++) begin
            wr(DMIC_BEEP_OFS, {2'h0, c[1:0], 4'h0});
            chk("first mic", {7'h00, FIRST_DIGITAL_MIC_INPUT_EN}, {7'h00, c == 1});
            chk("second mic", {7'h00, SECOND_DIGITAL_MIC_INPUT_EN}, {7'h00, c == 2});
            chk("front pd", {7'h00, FRONT_END_PD}, {7'h00, c == 1 || c == 2});
            chk("left power", {7'h00, INPUT_GAIN_AMPLIFIER[0].power}, {7'h00, c == 0 || c == 3});
            chk("right power", {7'h00, INPUT_GAIN_AMPLIFIER[1].power}, {7'h00, c == 0 || c == 3});
        end
        wr(DMIC_BEEP_OFS, 8'h00);
    endtask

    task automatic test_beep;
        for (int e = 0; e < 2; e++) begin
            wr(BEEP_ENABLE_OFS, (e == 1) ? 8'hFF : 8'hEF);
            for (int i = 0; i < 16; i++) begin
                wr(DMIC_BEEP_OFS, {4'hC, i[3:0]});
                chk("beep gain", {1'b0, BEEP_GAIN_DB}, {1'b0, BEEP_DB[i[2:0]]});
                chk("beep pass", {7'h00, BEEP_PASS}, {7'h00, i[3] & e[0]});
            end
        end
    endtask

    task automatic test_power;
        for (int i = 0; i < 4; i++) begin
            wr(REC_POWER_OFS, {1'b1, i[1:0], 2'(3 - i), i[1:0] ^ 2'h1, 1'b1});
            chk("boost", {6'h00, MIX_BOOST_LEVEL}, {6'h00, i[1:0]});
            chk("adc bias", {6'h00, ADC_BIAS_MODE}, {6'h00, 2'(3 - i)});
            chk("front bias", {6'h00, FRONT_END_BIAS_MODE}, {6'h00, i[1:0] ^ 2'h1});
        end
    endtask

    task automatic test_amp;
        logic [15:0] a;
        logic [7:0]  d;
        for (int ch = 0; ch < 2; ch++) begin
            a = (ch == 1) ? GAIN_RIGHT_OFS : GAIN_LEFT_OFS;
            for (int c = 0; c < 8; c++) begin
                d = {c[2:0], 2'h3, c[2:0]};
                wr(a, d);
                rd(a, d & 8'hE7);
                chk("amp gain", {2'h0, INPUT_GAIN_AMPLIFIER[ch].gain_db}, {2'h0, AMP_DB[c]});
                chk("amp pins", {5'h00, INPUT_GAIN_AMPLIFIER[ch].single_ended_mic_pin_sel,
                    INPUT_GAIN_AMPLIFIER[ch].positive_diff_pin_en,
                    INPUT_GAIN_AMPLIFIER[ch].complement_to_cm}, {5'h00, c[2], ~c[2], c[2]});
                chk("amp pass", {7'h00, INPUT_GAIN_AMPLIFIER[ch].pass}, {7'h00, c[1]});
                chk("amp power", {7'h00, INPUT_GAIN_AMPLIFIER[ch].power}, {7'h00, c[0]});
            end
        end
    endtask

    // ------------------------------------------------------------------
    // sequence and timeout
    // ------------------------------------------------------------------
    always @(posedge SYS_CLK) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            mismatches++;
            finish_test();
        end
    end

    initial begin
        RESET = 1'b1;
        REG_ADDR = 16'h0000;
        REG_WDATA = 8'h00;
        REG_WR_STB = 1'b0;
        REG_RD_STB = 1'b0;
        do_reset();
        check_reset_state();
        test_masks();
        test_dmic();
        test_beep();
        test_power();
        test_amp();
        // reset again with every register holding non-zero contents
        do_reset();
        check_reset_state();
        finish_test();
    end
endmodule
